// ==== logic/cops_clkout.sv ====
// Clock output pin generator with runt-free selection changes.
`default_nettype none

module cops_clkout (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Selection from the control register
	input wire logic [1:0] sel,
	// Pin and applied selection
	output logic clk_pin,
	output cops_pkg::cops_cksel_e mode
);
	import cops_pkg::*;

	typedef struct packed {
		cops_cksel_e mode;
		logic q;
	} cops_ck_s;

	cops_ck_s state_r;
	cops_ck_s state_nxt;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.mode = cops_cksel_e'(sel);
		// Leaving full clock at a rising edge keeps the level high, so the last pulse is whole.
		if (state_r.mode == CKSEL_FULL && cops_cksel_e'(sel) != CKSEL_FULL) begin
			state_nxt.q = 1'b1; // R8
		end else begin
			unique case (cops_cksel_e'(sel))
				CKSEL_FULL: state_nxt.q = 1'b1;
				CKSEL_DIV2: state_nxt.q = ~state_r.q; // R5 R8
				CKSEL_LOW: state_nxt.q = 1'b0; // R6
				CKSEL_HIGH: state_nxt.q = 1'b1; // R7
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= '{mode: CKSEL_FULL, q: 1'b1};
		end else begin
			state_r <= state_nxt;
		end
	end

	// The mux only switches at a rising edge, where the clock and the flip-flop agree high.
	assign clk_pin = (state_r.mode == CKSEL_FULL) ? core_clk : state_r.q; // R4
	assign mode = state_r.mode;

endmodule : cops_clkout

`default_nettype wire

// ==== logic/cops_pkg.sv ====
// Constants and types shared by the clock output select and port direction block.
//
// Overview of operation
// [R1] A zero direction bit makes the matching port pin an input.
// [R2] A one direction bit makes the matching port pin a driven output.
// [R3] Only control bits 7 and 6 select the clock output; writable anytime.
// [R4] Select 00 drives the clock pin with the undivided peripheral clock.
// [R5] Select 01 drives the clock pin with the peripheral clock divided by two.
// [R6] Select 10 turns the clock output off and holds the pin low.
// [R7] Select 11 stops the clock output and holds the pin high.
// [R8] Divide by two is a toggling flip-flop; selection changes give no runt pulse.
`default_nettype none

package cops_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int REG_W = 8;
	localparam logic [ADDR_W-1:0] OFS_GLOBAL_OUTPUT_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DIRECTION = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DATA = 4'h2;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CKSEL_HI = 7;
	localparam int CKSEL_LO = 6;
	localparam logic [REG_W-1:0] RST_GLOBAL_OUTPUT_CONTROL = 8'h00;
	localparam logic [REG_W-1:0] RST_PORT_E_DIRECTION = 8'h00;
	localparam logic [REG_W-1:0] RST_PORT_E_DATA = 8'h00;
	localparam logic [REG_W-1:0] RDATA_IDLE = 8'h00;

	// ****************************************************************
	// Clock output selections
	// ****************************************************************
	typedef enum logic [1:0] {
		CKSEL_FULL = 2'h0,
		CKSEL_DIV2 = 2'h1,
		CKSEL_LOW = 2'h2,
		CKSEL_HIGH = 2'h3
	} cops_cksel_e;

endpackage : cops_pkg

`default_nettype wire

// ==== logic/cops_top.sv ====
// Top of the clock output select and port direction block, with its register port.
`default_nettype none

module cops_top #(
	parameter int PORT_W = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [cops_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cops_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cops_pkg::REG_W-1:0] reg_rdata,
	// Clock output pin
	output logic clk_out_pin,
	// Parallel port pins
	input wire logic [PORT_W-1:0] pe_in,
	output logic [PORT_W-1:0] pe_out,
	output logic [PORT_W-1:0] pe_oe_n
);
	import cops_pkg::*;

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (PORT_W < 1 || PORT_W > REG_W) begin : g_bad_port_w
		$error("PORT_W must lie between 1 and the register width");
	end

	typedef struct packed {
		logic [REG_W-1:0] ctrl;
		logic [REG_W-1:0] dir;
		logic [REG_W-1:0] data;
		logic [PORT_W-1:0] sync1;
		logic [PORT_W-1:0] sync2;
		logic [REG_W-1:0] rdata;
	} cops_top_s;

	cops_top_s state_r;
	cops_top_s state_nxt;
	logic [REG_W-1:0] pins_rd;
	cops_cksel_e ck_mode;

	// ****************************************************************
	// Pin levels as read back
	// ****************************************************************
	// Output bits read the driven value; input bits read the synchronised pin.
	always_comb begin
		pins_rd = '0;
		for (int i = 0; i < PORT_W; i++) begin
			pins_rd[i] = state_r.dir[i] ? state_r.data[i] : state_r.sync2[i];
		end
	end

	// ****************************************************************
	// Register file and synchroniser
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.sync1 = pe_in;
		state_nxt.sync2 = state_r.sync1;
		state_nxt.rdata = RDATA_IDLE;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_GLOBAL_OUTPUT_CONTROL: state_nxt.ctrl = reg_wdata; // R3
				OFS_PORT_E_DIRECTION: state_nxt.dir = reg_wdata; // R1 R2
				OFS_PORT_E_DATA: state_nxt.data = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_GLOBAL_OUTPUT_CONTROL: state_nxt.rdata = state_r.ctrl;
				OFS_PORT_E_DIRECTION: state_nxt.rdata = state_r.dir;
				OFS_PORT_E_DATA: state_nxt.rdata = pins_rd;
				default: state_nxt.rdata = RDATA_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r.ctrl <= RST_GLOBAL_OUTPUT_CONTROL;
			state_r.dir <= RST_PORT_E_DIRECTION;
			state_r.data <= RST_PORT_E_DATA;
			state_r.sync1 <= '0;
			state_r.sync2 <= '0;
			state_r.rdata <= RDATA_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata = state_r.rdata;

	// ****************************************************************
	// Port pin drivers
	// ****************************************************************
	for (genvar b = 0; b < PORT_W; b++) begin : g_pin
		assign pe_oe_n[b] = ~state_r.dir[b]; // R1 R2
		assign pe_out[b] = state_r.data[b];
	end

	// ****************************************************************
	// Clock output
	// ****************************************************************
	// Software may rewrite the field at any time; the generator absorbs the change cleanly.
	cops_clkout u_clkout (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sel(state_r.ctrl[CKSEL_HI:CKSEL_LO]), // R3
		.clk_pin(clk_out_pin),
		.mode(ck_mode)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_dir_in;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_PORT_E_DIRECTION && reg_wdata == 8'h00)
			|=> (pe_oe_n == {PORT_W{1'b1}});
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("Direction zero did not release pins"); // R1

	property p_dir_out;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_PORT_E_DIRECTION && reg_wdata == 8'hff)
			|=> (pe_oe_n == {PORT_W{1'b0}} && pe_out == $past(pe_out));
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("Direction one did not drive pins"); // R2

	property p_sel_field;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_GLOBAL_OUTPUT_CONTROL)
			|=> ##1 (ck_mode == cops_cksel_e'($past(reg_wdata[CKSEL_HI:CKSEL_LO], 2)));
	endproperty
	a_sel_field: assert property (p_sel_field) else $error("Clock select not applied"); // R3

	property p_sel_only;
		@(posedge core_clk) disable iff (!rst_n)
		!(reg_wr && reg_addr == OFS_GLOBAL_OUTPUT_CONTROL)
			|=> $stable(state_r.ctrl[CKSEL_HI:CKSEL_LO]);
	endproperty
	a_sel_only: assert property (p_sel_only) else $error("Clock select changed unwritten"); // R3

	property p_full_high;
		@(negedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_FULL) |-> clk_out_pin;
	endproperty
	a_full_high: assert property (p_full_high) else $error("Full clock not high in high phase"); // R4

	property p_full_low;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_FULL) |-> !clk_out_pin;
	endproperty
	a_full_low: assert property (p_full_low) else $error("Full clock not low in low phase"); // R4

	property p_div2;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_DIV2 && $past(ck_mode) == CKSEL_DIV2)
			|-> (clk_out_pin != $past(clk_out_pin));
	endproperty
	a_div2: assert property (p_div2) else $error("Halved clock did not toggle"); // R5

	property p_low;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_LOW && $past(ck_mode) == CKSEL_LOW) |-> !clk_out_pin;
	endproperty
	a_low: assert property (p_low) else $error("Clock output not held low"); // R6

	property p_high;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_HIGH) [*2] |-> clk_out_pin;
	endproperty
	a_high: assert property (p_high) else $error("Clock output not held high"); // R7

	property p_no_runt;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode != CKSEL_FULL && $past(ck_mode) == CKSEL_FULL) |-> clk_out_pin;
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("Runt pulse on leaving full clock"); // R8

	// Pin level at the falling edge; in full clock mode this capture races the pin and is unused.
	logic pin_mid_r;

	always_ff @(negedge core_clk) begin
		if (!rst_n) begin
			pin_mid_r <= 1'b1;
		end else begin
			pin_mid_r <= clk_out_pin;
		end
	end

	property p_div2_duty;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_DIV2) |-> (clk_out_pin == pin_mid_r);
	endproperty
	a_div2_duty: assert property (p_div2_duty) else $error("Halved clock moved mid cycle"); // R8

	property p_rd_once;
		@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> (reg_rdata == RDATA_IDLE);
	endproperty
	a_rd_once: assert property (p_rd_once) else $error("Read data stood without a read");

	// ****************************************************************
	// Coverage
	// ****************************************************************
	property p_cv_div2;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_DIV2) [*4];
	endproperty
	c_cv_div2: cover property (p_cv_div2);

	property p_cv_full_to_low;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_FULL) ##1 (ck_mode == CKSEL_LOW) [*3];
	endproperty
	c_cv_full_to_low: cover property (p_cv_full_to_low);

	property p_cv_high;
		@(posedge core_clk) disable iff (!rst_n)
		(ck_mode == CKSEL_HIGH) [*3];
	endproperty
	c_cv_high: cover property (p_cv_high);

	property p_cv_all_out;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_PORT_E_DIRECTION && reg_wdata == 8'hff);
	endproperty
	c_cv_all_out: cover property (p_cv_all_out);

endmodule : cops_top

`default_nettype wire

// ==== sim/cops_board.sv ====
// Board-side model of the parallel port pins and the clock output load.
`default_nettype none

module cops_board #(
	parameter int PORT_W = 8,
	parameter logic [PORT_W-1:0] BOARD_LEVEL = 8'h96
) (
	// Pins from the device
	input wire logic [PORT_W-1:0] pe_out,
	input wire logic [PORT_W-1:0] pe_oe_n,
	input wire logic clk_out_pin,
	// Resolved pin levels back to the device
	output logic [PORT_W-1:0] pe_in,
	// Rising edges seen on the clock pin
	output int clk_rises
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Pin resolution
	// ****************************************************************
	// The board drives every pin the device leaves released, so a released pin never floats.
	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			pe_in[i] = pe_oe_n[i] ? BOARD_LEVEL[i] : pe_out[i];
		end
	end

	// ****************************************************************
	// Clock pin load
	// ****************************************************************
	// The bench compares differences of this count, so the start value is of no concern.
	initial clk_rises = 0;

	always @(posedge clk_out_pin) begin
		clk_rises <= clk_rises + 1;
	end

endmodule : cops_board

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench of the clock output select and port direction block.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cops_pkg::*;

	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [REG_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [REG_W-1:0] reg_rdata;
	logic clk_out_pin;
	logic [7:0] pe_in;
	logic [7:0] pe_out;
	logic [7:0] pe_oe_n;
	logic [7:0] d;
	int fails = 0;
	int check_count = 0;
	int clk_rises;

	always #20 core_clk = ~core_clk;

	cops_top #(.PORT_W(8)) cops_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .clk_out_pin(clk_out_pin), .pe_in(pe_in),
		.pe_out(pe_out), .pe_oe_n(pe_oe_n));

	cops_board #(.PORT_W(8), .BOARD_LEVEL(8'h96)) cops_board_i (.pe_out(pe_out),
		.pe_oe_n(pe_oe_n), .clk_out_pin(clk_out_pin), .pe_in(pe_in),
		.clk_rises(clk_rises));

	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Samples the pin in the high and the low half of several cycles after a selection.
	task automatic ck_mode(input logic [1:0] sel);
		logic h;
		logic l;
		logic prev;
		int rises;
		wr(OFS_GLOBAL_OUTPUT_CONTROL, {sel, 6'h2a});
		rd(OFS_GLOBAL_OUTPUT_CONTROL, d);
		chk(d, {sel, 6'h2a}, "control read back");
		repeat (3) @(posedge core_clk);
		#10 prev = clk_out_pin;
		rises = clk_rises;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			#10 h = clk_out_pin;
			#20 l = clk_out_pin;
			case (sel)
				2'h0: chk({6'h0, h, l}, 8'h02, "full clock");
				2'h1: chk({6'h0, h, l}, {6'h0, ~prev, ~prev}, "half clock");
				2'h2: chk({6'h0, h, l}, 8'h00, "held low");
				default: chk({6'h0, h, l}, 8'h03, "held high");
			endcase
			prev = h;
		end
		case (sel)
			2'h0: chk(8'(clk_rises - rises), 8'h04, "full clock pulses");
			2'h1: chk(8'(clk_rises - rises), 8'h02, "half clock pulses");
			default: chk(8'(clk_rises - rises), 8'h00, "static clock pulses");
		endcase
		$display("Test clock select %0d done", sel);
	endtask : ck_mode

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFS_GLOBAL_OUTPUT_CONTROL, d);
		chk(d, RST_GLOBAL_OUTPUT_CONTROL, "control reset");
		rd(OFS_PORT_E_DIRECTION, d);
		chk(d, RST_PORT_E_DIRECTION, "direction reset");
		rd(4'hf, d);
		chk(d, RDATA_IDLE, "unmapped read");
		chk(pe_oe_n, 8'hff, "pins released after reset");
		$display("Test reset values done");
		wr(OFS_PORT_E_DIRECTION, 8'hff);
		#1 chk(pe_oe_n, 8'h00, "all outputs");
		wr(OFS_PORT_E_DIRECTION, 8'h00);
		#1 chk(pe_oe_n, 8'hff, "all inputs");
		wr(4'hf, 8'hff);
		#1 chk(pe_oe_n, 8'hff, "unmapped write ignored");
		wr(OFS_PORT_E_DATA, 8'h3c);
		wr(OFS_PORT_E_DIRECTION, 8'h0f);
		#1 chk(pe_oe_n, 8'hf0, "mixed direction");
		chk(pe_out & 8'h0f, 8'h0c, "driven values");
		repeat (4) @(posedge core_clk);
		rd(OFS_PORT_E_DATA, d);
		chk(d, 8'h9c, "pin read back");
		rd(OFS_PORT_E_DIRECTION, d);
		chk(d, 8'h0f, "direction read back");
		$display("Test port direction done");
		ck_mode(2'h1);
		ck_mode(2'h2);
		ck_mode(2'h0);
		ck_mode(2'h3);
		ck_mode(2'h1);
		ck_mode(2'h0);
		ck_mode(2'h2);
		tally_and_finish();
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

endmodule : tb_top

`default_nettype wire
